// [brmcs_stage.sv]
// blit per-pixel combine stage with its parameter registers
// Operation
// - 12-bit row pitch at index 1000
// - pitch uses same units as positions
// - pitch steps only rectangular regions
// - foreground colour index 1010, planar low four
// - background colour index 1011, planar low four
// - fg/bg replace monochrome source pixels
// - zero gives background, one gives foreground
// - foreground as fixed source fills rectangle
// - mask bits 3:0 enable map writes
// - mask bits 7:0 enable packed planes
// - mask register index 1110, planar low four
// - four-bit raster code at index 1001
// - result is bitwise function of S,D
// - code bits a,b,c,d for SD 00..11
// - 0011 source, 1100 inverted, 0101 destination
// - logical operations only, no arithmetic
// - 8 by 8 pattern tiled over destination
// - pattern anchored top-left, wraps right, down
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module brmcs_stage
  import brmcs_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic clk, // 250 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic [4:0] regAddr, // register index
  input wire logic [15:0] regWrData, // write data
  input wire logic regWrStrobe, // write strobe
  input wire logic regRdStrobe, // read strobe
  output logic [15:0] regRdData, // read data, cycle after strobe
  input wire logic pixValid, // pixel presented
  input wire logic [7:0] srcPix, // colour source pixel
  input wire logic srcMonoBit, // monochrome source bit
  input wire logic [7:0] dstPix, // current destination pixel
  input wire logic [5:0] patStart, // pattern pixel at top-left corner
  input wire logic [2:0] dstOffX, // destination x offset in region
  input wire logic [2:0] dstOffY, // destination y offset in region
  output logic pixOutValid, // result valid
  output logic [7:0] pixOut, // masked result pixel
  output logic [5:0] patIndex, // pattern pixel to fetch
  input wire logic rowStep, // advance to next row
  input wire logic [ADDR_W-1:0] srcRowBase, // source position this row
  input wire logic [ADDR_W-1:0] dstRowBase, // destination position this row
  output logic rowOutValid, // next-row positions valid
  output logic [ADDR_W-1:0] srcRowNext, // source position next row
  output logic [ADDR_W-1:0] dstRowNext // destination position next row
);

  // ******************************
  // functions
  // ******************************
  // code bit a is the high bit and answers S=0,D=0
  function automatic logic rop_bit(input logic [3:0] code, input logic s, input logic d);
    rop_bit = code[2'd3 - {s, d}];
  endfunction

  // planar modes see only the low four bits
  function automatic logic [7:0] mode_trim(input logic [7:0] v, input logic packed_mode);
    mode_trim = packed_mode ? v : (v & BRMCS_PLANAR_KEEP);
  endfunction

  // byte-wide registers read back with their index code and zeroed reserved bits
  function automatic logic [15:0] byte_readback(input logic [3:0] idx, input logic [7:0] v);
    byte_readback = {idx, 4'h0, v};
  endfunction

  // next-row position; regions that are not rectangular do not step
  function automatic logic [ADDR_W-1:0] row_advance(input logic [ADDR_W-1:0] base, input logic [11:0] pitch,
    input logic rect);
    row_advance = rect ? ADDR_W'(base + ADDR_W'(pitch)) : base;
  endfunction

  // ******************************
  // registers
  // ******************************
  logic [11:0] rowPitch_reg;
  logic [3:0] rasterOp_reg;
  logic [7:0] fgColour_reg;
  logic [7:0] bgColour_reg;
  logic [7:0] writeMask_reg;
  logic [BRMCS_CFG_MSB:0] config_reg;
  logic [15:0] pixCount_reg;
  logic [15:0] regRdData_reg;
  logic pixOutValid_reg;
  logic [7:0] pixOut_reg;
  logic [5:0] patIndex_reg;
  logic rowOutValid_reg;
  logic [ADDR_W-1:0] srcRowNext_reg;
  logic [ADDR_W-1:0] dstRowNext_reg;

  logic packedMode;
  logic [1:0] srcSelect;
  logic patternSizeSelect;
  logic [7:0] fgEff;
  logic [7:0] bgEff;
  logic [7:0] maskEff;
  logic [7:0] srcEff;
  logic [7:0] ropResult;
  logic [7:0] pixOut_next;

  assign packedMode = config_reg[BRMCS_CFG_PACKED];
  assign srcSelect = config_reg[BRMCS_CFG_SRC_MSB:BRMCS_CFG_SRC_LSB];
  assign patternSizeSelect = config_reg[BRMCS_CFG_PATTERN];

  // ******************************
  // register writes
  // ******************************
  // the index code in the top nibble of a write is not checked; the address selects
  always_ff @(posedge clk) begin
    if (reset) begin
      rowPitch_reg <= BRMCS_PITCH_RESET;
      rasterOp_reg <= BRMCS_ROP_RESET;
      fgColour_reg <= BRMCS_FG_RESET;
      bgColour_reg <= BRMCS_BG_RESET;
      writeMask_reg <= BRMCS_MASK_RESET;
      config_reg <= BRMCS_CFG_RESET;
    end else if (regWrStrobe) begin
      unique case (regAddr)
        BRMCS_IDX_ROW_PITCH: rowPitch_reg <= regWrData[BRMCS_PITCH_MSB:0];
        BRMCS_IDX_RASTER_OP: rasterOp_reg <= regWrData[BRMCS_ROP_MSB:BRMCS_ROP_LSB];
        BRMCS_IDX_FG_COLOUR: fgColour_reg <= regWrData[BRMCS_COLOUR_MSB:0];
        BRMCS_IDX_BG_COLOUR: bgColour_reg <= regWrData[BRMCS_COLOUR_MSB:0];
        BRMCS_IDX_WRITE_MASK: writeMask_reg <= regWrData[BRMCS_COLOUR_MSB:0];
        BRMCS_IDX_CONFIG: config_reg <= regWrData[BRMCS_CFG_MSB:0];
        default: ;
      endcase
    end
  end

  // ******************************
  // register reads
  // ******************************
  // reserved bits read zero, the index code reads back in the top nibble; status returns the whole 16-bit count instead
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData_reg <= 16'h0000;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        BRMCS_IDX_ROW_PITCH: regRdData_reg <= {regAddr[3:0], rowPitch_reg};
        BRMCS_IDX_RASTER_OP: regRdData_reg <= {regAddr[3:0], rasterOp_reg, 8'h00};
        BRMCS_IDX_FG_COLOUR: regRdData_reg <= byte_readback(regAddr[3:0], fgColour_reg);
        BRMCS_IDX_BG_COLOUR: regRdData_reg <= byte_readback(regAddr[3:0], bgColour_reg);
        BRMCS_IDX_WRITE_MASK: regRdData_reg <= byte_readback(regAddr[3:0], writeMask_reg);
        BRMCS_IDX_CONFIG: regRdData_reg <= {10'h000, config_reg};
        BRMCS_IDX_STATUS: regRdData_reg <= pixCount_reg;
        default: regRdData_reg <= 16'h0000;
      endcase
    end else begin
      regRdData_reg <= 16'h0000;
    end
  end

  // ******************************
  // pixel combine
  // ******************************
  always_comb begin
    fgEff = mode_trim(fgColour_reg, packedMode);
    bgEff = mode_trim(bgColour_reg, packedMode);
    maskEff = mode_trim(writeMask_reg, packedMode);
    unique case (srcSelect)
      BRMCS_SRC_MONO: srcEff = srcMonoBit ? fgEff : bgEff;
      BRMCS_SRC_FIXED_FG: srcEff = fgEff;
      default: srcEff = srcPix;
    endcase
    // purely bitwise: no carries ever cross between bits
    for (int i = 0; i < 8; i++) begin
      ropResult[i] = rop_bit(rasterOp_reg, srcEff[i], dstPix[i]);
    end
    // masked-off maps or planes keep the old destination bits
    pixOut_next = (ropResult & maskEff) | (dstPix & ~maskEff);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pixOutValid_reg <= 1'b0;
      pixOut_reg <= 8'h00;
    end else begin
      pixOutValid_reg <= pixValid;
      if (pixValid) begin
        pixOut_reg <= pixOut_next;
      end
    end
  end

  // pattern position wraps inside the 8 by 8 tile; outside pattern mode it follows patStart
  always_ff @(posedge clk) begin
    if (reset) begin
      patIndex_reg <= 6'h00;
    end else if (pixValid) begin
      if (patternSizeSelect) begin
        patIndex_reg <= {3'(patStart[5:3] + dstOffY), 3'(patStart[2:0] + dstOffX)};
      end else begin
        patIndex_reg <= patStart;
      end
    end
  end

  // status: pixels combined since reset, wraps
  always_ff @(posedge clk) begin
    if (reset) begin
      pixCount_reg <= 16'h0000;
    end else if (pixValid) begin
      pixCount_reg <= 16'(pixCount_reg + 16'h0001);
    end
  end

  // ******************************
  // row stepping
  // ******************************
  // pitch added unscaled: it is already in the units of the position fields
  always_ff @(posedge clk) begin
    if (reset) begin
      rowOutValid_reg <= 1'b0;
      srcRowNext_reg <= '0;
      dstRowNext_reg <= '0;
    end else begin
      rowOutValid_reg <= rowStep;
      if (rowStep) begin
        srcRowNext_reg <= row_advance(srcRowBase, rowPitch_reg, config_reg[BRMCS_CFG_SRC_RECT]);
        dstRowNext_reg <= row_advance(dstRowBase, rowPitch_reg, config_reg[BRMCS_CFG_DST_RECT]);
      end
    end
  end

  assign regRdData = regRdData_reg;
  assign pixOutValid = pixOutValid_reg;
  assign pixOut = pixOut_reg;
  assign patIndex = patIndex_reg;
  assign rowOutValid = rowOutValid_reg;
  assign srcRowNext = srcRowNext_reg;
  assign dstRowNext = dstRowNext_reg;

endmodule // brmcs_stage

// [brmcs_pkg.sv]
// constants for the blit combine stage: register indices, fields, reset values
package brmcs_pkg;

  // ******************************
  // register indices (address port)
  // ******************************
  localparam logic [4:0] BRMCS_IDX_ROW_PITCH = 5'h08;
  localparam logic [4:0] BRMCS_IDX_RASTER_OP = 5'h09;
  localparam logic [4:0] BRMCS_IDX_FG_COLOUR = 5'h0A;
  localparam logic [4:0] BRMCS_IDX_BG_COLOUR = 5'h0B;
  localparam logic [4:0] BRMCS_IDX_WRITE_MASK = 5'h0E;
  localparam logic [4:0] BRMCS_IDX_CONFIG = 5'h10;
  localparam logic [4:0] BRMCS_IDX_STATUS = 5'h11;

  // ******************************
  // field positions
  // ******************************
  localparam int BRMCS_INDEX_MSB = 15;
  localparam int BRMCS_INDEX_LSB = 12;
  localparam int BRMCS_PITCH_MSB = 11;
  localparam int BRMCS_ROP_MSB = 11;
  localparam int BRMCS_ROP_LSB = 8;
  localparam int BRMCS_COLOUR_MSB = 7;
  localparam int BRMCS_CFG_PACKED = 0;
  localparam int BRMCS_CFG_SRC_LSB = 1;
  localparam int BRMCS_CFG_SRC_MSB = 2;
  localparam int BRMCS_CFG_PATTERN = 3;
  localparam int BRMCS_CFG_SRC_RECT = 4;
  localparam int BRMCS_CFG_DST_RECT = 5;
  localparam int BRMCS_CFG_MSB = 5;

  // ******************************
  // source select codes
  // ******************************
  localparam logic [1:0] BRMCS_SRC_COLOUR = 2'h0;
  localparam logic [1:0] BRMCS_SRC_MONO = 2'h1;
  localparam logic [1:0] BRMCS_SRC_FIXED_FG = 2'h2;

  // ******************************
  // reset values
  // ******************************
  localparam logic [11:0] BRMCS_PITCH_RESET = 12'h000;
  localparam logic [3:0] BRMCS_ROP_RESET = 4'h3;
  localparam logic [7:0] BRMCS_FG_RESET = 8'h00;
  localparam logic [7:0] BRMCS_BG_RESET = 8'h00;
  localparam logic [7:0] BRMCS_MASK_RESET = 8'hFF;
  localparam logic [5:0] BRMCS_CFG_RESET = 6'h00;

  // planar modes use only the low four bits of colours and masks
  localparam logic [7:0] BRMCS_PLANAR_KEEP = 8'h0F;

endpackage

// [brmcs_mem_model.sv]
// display memory model: one aligned 64-byte block feeding destination pixels
`timescale 1ns/1ps

module brmcs_mem_model (
  input wire logic [5:0] memAddr, // byte within the block
  output logic [7:0] memData // stored byte
);
  // ****************
  // storage
  // ****************
  logic [7:0] mem [64];

  // fixed fill so the stored bytes do not depend on the run
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 90);
  end

  assign memData = mem[memAddr];
endmodule // brmcs_mem_model

// [brmcs_stage_chk.sv]
// port checker for the blit combine stage
`timescale 1ns/1ps

module brmcs_stage_chk
  import brmcs_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic [4:0] regAddr, // index
  input wire logic regRdStrobe, // read strobe
  input wire logic [15:0] regRdData, // read data
  input wire logic pixValid, // pixel in
  input wire logic pixOutValid, // pixel out
  input wire logic [7:0] pixOut, // result
  input wire logic rowStep, // row request
  input wire logic rowOutValid // row answer
);
  // ****************
  // assertions
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_pix_answer: assert property (pixValid |=> pixOutValid) else $error("pixel result missing");
  a_pix_hold: assert property (!pixValid |=> !pixOutValid && $stable(pixOut)) else $error("pixel moved");
  a_row_answer: assert property (rowStep |=> rowOutValid) else $error("row answer missing");
  a_row_quiet: assert property (!rowStep |=> !rowOutValid) else $error("row answer unasked");
  a_rd_idle: assert property (!regRdStrobe |=> regRdData == 16'h0000) else $error("read data not cleared");
  a_pitch_code: assert property (regRdStrobe && regAddr == BRMCS_IDX_ROW_PITCH |=> regRdData[15:12] == 4'h8)
    else $error("pitch index code wrong");
  a_rop_code: assert property (regRdStrobe && regAddr == BRMCS_IDX_RASTER_OP |=> regRdData[15:12] == 4'h9
    && regRdData[7:0] == 8'h00) else $error("raster read wrong");
  a_fg_code: assert property (regRdStrobe && regAddr == BRMCS_IDX_FG_COLOUR |=> regRdData[15:8] == 8'hA0)
    else $error("foreground read wrong");
  a_bg_code: assert property (regRdStrobe && regAddr == BRMCS_IDX_BG_COLOUR |=> regRdData[15:8] == 8'hB0)
    else $error("background read wrong");
  a_mask_code: assert property (regRdStrobe && regAddr == BRMCS_IDX_WRITE_MASK |=> regRdData[15:8] == 8'hE0)
    else $error("mask read wrong");
endmodule // brmcs_stage_chk

bind brmcs_stage brmcs_stage_chk chk (.clk(clk), .reset(reset), .regAddr(regAddr), .regRdStrobe(regRdStrobe),
  .regRdData(regRdData), .pixValid(pixValid), .pixOutValid(pixOutValid), .pixOut(pixOut), .rowStep(rowStep),
  .rowOutValid(rowOutValid));

// [tb_blit_rop_mask_color_stage.sv]
// self-checking bench for the blit combine stage
`timescale 1ns/1ps

module tb_blit_rop_mask_color_stage;
  import brmcs_pkg::*;
  logic clk = 0, reset = 1, regWrStrobe = 0, regRdStrobe = 0, pixValid = 0, srcMonoBit = 0, rowStep = 0, rdSeen = 0;
  logic pixOutValid, rowOutValid;
  logic [4:0] regAddr = 0;
  logic [15:0] regWrData = 0, regRdData;
  logic [7:0] srcPix = 0, dstPix, pixOut, fg, bg, m;
  logic [5:0] patStart = 0, patIndex, memAddr = 0, cfg = 0;
  logic [2:0] dstOffX = 0, dstOffY = 0;
  logic [19:0] srcRowBase = 0, dstRowBase = 0, srcRowNext, dstRowNext;
  logic [11:0] pitch;
  logic [3:0] code;
  logic [31:0] r;
  logic [15:0] qRd [$];
  logic [13:0] qPix [$];
  logic [39:0] qRow [$];
  // last entry: planar pattern copy with a single-plane monochrome source
  logic [5:0] cfgTab [5] = '{6'h09, 6'h03, 6'h05, 6'h02, 6'h0A};
  int err_count = 0, check_count = 0, seed = 8;

  brmcs_stage dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .pixValid(pixValid), .srcPix(srcPix), .srcMonoBit(srcMonoBit),
    .dstPix(dstPix), .patStart(patStart), .dstOffX(dstOffX), .dstOffY(dstOffY), .pixOutValid(pixOutValid),
    .pixOut(pixOut), .patIndex(patIndex), .rowStep(rowStep), .srcRowBase(srcRowBase), .dstRowBase(dstRowBase),
    .rowOutValid(rowOutValid), .srcRowNext(srcRowNext), .dstRowNext(dstRowNext));
  brmcs_mem_model mem (.memAddr(memAddr), .memData(dstPix));

  // ****************
  // tasks
  // ****************
  initial forever #2 clk = ~clk;

  task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a, logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    qRd.push_back(e);
    @(posedge clk);
    regRdStrobe <= 1'b0;
  endtask

  function automatic logic [7:0] rop(logic [7:0] a, logic [7:0] b);
    logic [7:0] t;
    for (int i = 0; i < 8; i++) t[i] = code[3 - int'({a[i], b[i]})];
    return t;
  endfunction

  task automatic px();
    logic [7:0] sv, k, mk;
    @(posedge clk);
    r = $random(seed);
    srcPix <= r[7:0];
    srcMonoBit <= r[8];
    patStart <= r[14:9];
    dstOffX <= r[17:15];
    dstOffY <= r[20:18];
    memAddr <= r[26:21];
    pixValid <= 1'b1;
    #1;
    // planar modes keep only the low four bits of colours and mask
    k = cfg[0] ? 8'hFF : 8'h0F;
    sv = cfg[2:1] == 2'h1 ? (srcMonoBit ? fg : bg) & k : cfg[2:1] == 2'h2 ? fg & k : srcPix;
    mk = m & k;
    qPix.push_back({cfg[3] ? {patStart[5:3] + dstOffY, patStart[2:0] + dstOffX} : patStart,
      (rop(sv, dstPix) & mk) | (dstPix & ~mk)});
    @(posedge clk);
    pixValid <= 1'b0;
  endtask

  task automatic row();
    @(posedge clk);
    r = $random(seed);
    srcRowBase <= r[19:0];
    dstRowBase <= {r[11:0], r[31:24]};
    rowStep <= 1'b1;
    qRow.push_back({cfg[4] ? r[19:0] + pitch : r[19:0], cfg[5] ? {r[11:0], r[31:24]} + pitch : {r[11:0], r[31:24]}});
    @(posedge clk);
    rowStep <= 1'b0;
  endtask

  // ****************
  // monitor and sequence
  // ****************
  always @(posedge clk) begin
    rdSeen <= regRdStrobe & ~reset;
    if (rdSeen) check("regRdData", 40'(regRdData), 40'(qRd.pop_front()));
    if (pixOutValid) check("pixel", 40'({patIndex, pixOut}), 40'(qPix.pop_front()));
    if (rowOutValid) check("rowNext", {srcRowNext, dstRowNext}, qRow.pop_front());
  end

  initial begin
    #40000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(BRMCS_IDX_ROW_PITCH, 16'h8000);
    rd(BRMCS_IDX_RASTER_OP, 16'h9300);
    rd(BRMCS_IDX_FG_COLOUR, 16'hA000);
    rd(BRMCS_IDX_BG_COLOUR, 16'hB000);
    rd(BRMCS_IDX_WRITE_MASK, 16'hE0FF);
    r = $random(seed);
    pitch = r[11:0] & 12'hFFC;
    {fg, bg, m} = r[31:8];
    wr(BRMCS_IDX_ROW_PITCH, {4'hF, pitch});
    rd(BRMCS_IDX_ROW_PITCH, {4'h8, pitch});
    wr(BRMCS_IDX_FG_COLOUR, {8'hFF, fg});
    rd(BRMCS_IDX_FG_COLOUR, {8'hA0, fg});
    wr(BRMCS_IDX_BG_COLOUR, {8'hFF, bg});
    rd(BRMCS_IDX_BG_COLOUR, {8'hB0, bg});
    wr(BRMCS_IDX_WRITE_MASK, {8'hFF, m});
    rd(BRMCS_IDX_WRITE_MASK, {8'hE0, m});
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      cfg = cfgTab[k];
      wr(BRMCS_IDX_CONFIG, {10'h000, cfg});
      for (int c = 0; c < 16; c++) begin
        code = 4'(c);
        wr(BRMCS_IDX_RASTER_OP, {4'h0, code, 8'hFF});
        rd(BRMCS_IDX_RASTER_OP, {4'h9, code, 8'h00});
        px();
        px();
      end
    end
    for (int k = 0; k < 4; k++) begin
      cfg = {2'(k), 4'h1};
      wr(BRMCS_IDX_CONFIG, {10'h000, cfg});
      rd(BRMCS_IDX_CONFIG, {10'h000, cfg});
      row();
    end
    // five configurations, sixteen codes, two pixels each
    rd(BRMCS_IDX_STATUS, 16'h00A0);
    repeat (2) @(posedge clk);
    // mid-run reset must bring the registers back to their reset values
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(BRMCS_IDX_ROW_PITCH, 16'h8000);
    rd(BRMCS_IDX_WRITE_MASK, 16'hE0FF);
    rd(BRMCS_IDX_STATUS, 16'h0000);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule // tb_blit_rop_mask_color_stage
